// ===== sample_fifo_status_trigger.sv
/*
  status and trigger control around the 32-sample fifo: count, overflow, watermark/trigger flags,
  trigger gating, gate error with elapsed time, system mode and the address-zero status alias.
  assumes the register port, fifo events, detector flags and rate tick are synchronous to mclk,
  and that the fifo core honours fifoAccept.
*/
`timescale 1ns/1ps
module sample_fifo_status_trigger (
  // clock and reset
  input  wire logic                       mclk,
  input  wire logic                       rst,
  // register port
  input  wire logic [7:0]                 regAddr,
  input  wire logic                       regRd,
  input  wire logic                       regWr,
  input  wire logic [7:0]                 regWrData,
  output logic      [7:0]                 regRdData,
  // fifo setup and events
  input  wire logic [1:0]                 fifoMode,
  input  wire logic [5:0]                 fifoWatermark,
  input  wire sfst_pkg::sfst_fifo_ev_type fifoEv,
  output logic                            fifoAccept,
  // per-axis alias source
  input  wire logic [7:0]                 axisReadyStatus,
  // detectors, gate error, rate tick
  input  wire sfst_pkg::sfst_detect_type  detectFlags,
  input  wire logic                       gateErrEvent,
  input  wire logic                       outputRateTick,
  // power mode
  input  wire logic                       wakeReq,
  input  wire logic                       sleepReq,
  input  wire logic                       standbyReq,
  input  wire logic                       aslpEvent,
  // interrupt source bits
  output logic                            srcFifo,
  output logic                            srcAslp
);
  import sfst_pkg::*;

  logic [5:0]     sampleCnt_reg;
  logic [7:0]     trigCfg_reg;
  logic           overflow_reg;
  logic           trigHit_reg;
  logic           gateErr_reg;
  logic [4:0]     gateTime_reg;
  sfst_state_type sysState_reg;
  sfst_state_type sysState_next;
  logic           srcFifoArmed_reg;
  logic [1:0]     sysCode;
  logic           gateErrClr;
  logic [7:0]     statusByte;
  logic [7:0]     sysByte;
  logic           wmrkFlag;
  logic           trigFire;
  logic           pushOk;
  logic           popOk;
  logic           rdStatus;
  logic           rdSys;
  logic [7:0]     snapRd;

  // trigger fires when an enabled detector raises its flag in trigger mode
  assign trigFire   = (fifoMode == SFST_MODE_TRIG) && |(trigCfg_reg[5:1] & detectFlags);
  assign pushOk     = fifoEv.sampleIn && !trigHit_reg && !trigFire;
  assign popOk      = fifoEv.sampleOut && (sampleCnt_reg != SFST_CNT_EMPTY);
  assign wmrkFlag   = (fifoMode == SFST_MODE_TRIG) ? trigHit_reg
                                                  : (sampleCnt_reg >= fifoWatermark);
  assign statusByte = {overflow_reg, wmrkFlag, sampleCnt_reg};
  assign sysByte    = {gateErr_reg, gateTime_reg, sysCode};
  // emptying clears the gate error unless a new error lands in the same cycle
  assign gateErrClr = !gateErrEvent && (sampleCnt_reg == SFST_CNT_EMPTY);
  assign rdStatus   = regRd && (regAddr == SFST_ADDR_STATUS) && (fifoMode != SFST_MODE_OFF);
  assign rdSys      = regRd && (regAddr == SFST_ADDR_SYSMODE);

  // sample count, saturating; overflow push in fifo mode keeps full
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      sampleCnt_reg <= SFST_CNT_EMPTY;
    end else if (fifoEv.flush) begin
      sampleCnt_reg <= SFST_CNT_EMPTY;
    end else if (pushOk && !popOk && sampleCnt_reg != SFST_CNT_FULL) begin
      sampleCnt_reg <= sampleCnt_reg + 6'h01;
    end else if (popOk && !pushOk) begin
      sampleCnt_reg <= sampleCnt_reg - 6'h01;
    end
  end

  // fifo core may store only while not gated
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      fifoAccept <= 1'b1;
    end else begin
      fifoAccept <= !(trigHit_reg || trigFire);
    end
  end

  // overflow is a condition, not a latched event: only draining or fifo mode off ends it
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      overflow_reg <= 1'b0;
    end else if (fifoEv.flush || popOk || fifoMode == SFST_MODE_OFF) begin
      overflow_reg <= 1'b0;
    end else if (pushOk && sampleCnt_reg == SFST_CNT_FULL) begin
      overflow_reg <= 1'b1;
    end
  end

  // trigger latch; released when trigger mode is left or fifo flushed
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      trigHit_reg <= 1'b0;
    end else if (trigFire) begin
      trigHit_reg <= 1'b1;
    end else if (fifoMode != SFST_MODE_TRIG || fifoEv.flush) begin
      trigHit_reg <= 1'b0;
    end
  end

  // trigger configuration, unused bits forced low
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      trigCfg_reg <= SFST_RESET_BYTE;
    end else if (regWr && regAddr == SFST_ADDR_TRIGCFG) begin
      trigCfg_reg <= regWrData & SFST_TRIG_MASK;
    end
  end

  // gate error; a new error outranks the emptying clear
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      gateErr_reg <= 1'b0;
    end else if (gateErrEvent) begin
      gateErr_reg <= 1'b1;
    end else if (sampleCnt_reg == SFST_CNT_EMPTY) begin
      gateErr_reg <= 1'b0;
    end
  end

  // elapsed rate periods since gate error, saturating
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      gateTime_reg <= 5'h00;
    end else if (!gateErr_reg || gateErrClr) begin
      gateTime_reg <= 5'h00; // cleared in the same cycle as the flag
    end else if (outputRateTick && gateTime_reg != SFST_FGT_MAX) begin
      gateTime_reg <= gateTime_reg + 5'h01;
    end
  end

  // power mode sequencer; standby wins over everything
  always_comb begin
    sysState_next = sysState_reg;
    case (sysState_reg)
      SFST_ST_STANDBY: begin
        if (wakeReq) sysState_next = SFST_ST_WAKE;
      end
      SFST_ST_WAKE: begin
        if (sleepReq) sysState_next = SFST_ST_SLEEP;
      end
      SFST_ST_SLEEP: begin
        if (wakeReq) sysState_next = SFST_ST_WAKE;
      end
      default: sysState_next = SFST_ST_STANDBY;
    endcase
    if (standbyReq) sysState_next = SFST_ST_STANDBY;
  end

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      sysState_reg <= SFST_ST_STANDBY;
    end else begin
      sysState_reg <= sysState_next;
    end
  end

  // state encoding is gray internally; the host sees the documented mode codes
  always_comb begin
    case (sysState_reg)
      SFST_ST_WAKE:  sysCode = SFST_SYS_WAKE;
      SFST_ST_SLEEP: sysCode = SFST_SYS_SLEEP;
      default:       sysCode = SFST_SYS_STANDBY;
    endcase
  end

  // fifo source bit; set beats clear, re-armed by next sample after a read
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      srcFifo          <= 1'b0;
      srcFifoArmed_reg <= 1'b0;
    end else if ((pushOk && sampleCnt_reg == SFST_CNT_FULL) ||
                 (pushOk && (sampleCnt_reg + 6'h01) == fifoWatermark)) begin
      srcFifo          <= 1'b1;
      srcFifoArmed_reg <= 1'b0;
    end else if (srcFifoArmed_reg && pushOk && (overflow_reg || wmrkFlag)) begin
      srcFifo          <= 1'b1;
      srcFifoArmed_reg <= 1'b0;
    end else if (rdStatus) begin
      srcFifo          <= 1'b0;
      srcFifoArmed_reg <= 1'b1;
    end
  end

  // auto-sleep source bit; a new event in the read cycle survives
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      srcAslp <= 1'b0;
    end else if (aslpEvent) begin
      srcAslp <= 1'b1;
    end else if (rdSys) begin
      srcAslp <= 1'b0;
    end
  end

  // snapshot of the alias byte; snapRd is not used, the read mux serves address zero live
  sfst_snap_mem u_snap (
    .mclk   (mclk),
    .rst    (rst),
    .wrEn   (1'b1),
    .wrAddr (2'h0),
    .wrData ((fifoMode != SFST_MODE_OFF) ? statusByte : axisReadyStatus),
    .rdAddr (2'h0),
    .rdData (snapRd)
  );

  // read mux; address zero served live, others from state, unmapped read as zero
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      regRdData <= SFST_RESET_BYTE;
    end else begin
      case (regAddr)
        SFST_ADDR_STATUS:  regRdData <= (fifoMode != SFST_MODE_OFF) ? statusByte : axisReadyStatus;
        SFST_ADDR_TRIGCFG: regRdData <= trigCfg_reg;
        SFST_ADDR_SYSMODE: regRdData <= sysByte;
        default:           regRdData <= SFST_RESET_BYTE;
      endcase
    end
  end
endmodule

// ===== sfst_pkg.sv
/*
  constants, field layouts and carrier structs for the sample fifo status and trigger block.
  assumes a register access port inside the device (address, read/write strobes) and event
  inputs from the fifo core, the detectors and the power-mode logic.
*/
// Behaviour
// - Nonzero fifo output mode makes address zero return fifo status byte.
// - Fifo output mode zero makes address zero return per-axis data-ready status.
// - Overflow flag follows overflowed condition; status reads never clear it.
// - Watermark flag high whenever sample count is at or above watermark.
// - In trigger mode the watermark position reports a detected trigger event.
// - Reading fifo status clears fifo interrupt source bit, flags untouched.
// - After such clear, next entering sample re-sets source bit if flag active.
// - Fifo interrupt source bit sets on overflow or count equal watermark.
// - Six-bit count reports samples held, zero empty, up to thirty-two, resets zero.
// - In trigger mode an enabled detector flag gates the fifo from new samples.
// - Trigger config holds five detector enables; unused bits zero; resets zero.
// - Gate error flag sets on gate error, resets zero, clears when fifo emptied.
// - Five-bit elapsed count counts rate periods since gate error; zero when cleared.
// - System mode field reports standby 00, wake 01, sleep 10; defaults standby.
// - Reading system mode register clears the auto-sleep/wake source bit.
package sfst_pkg;
  localparam logic [7:0] SFST_ADDR_STATUS  = 8'h00;
  localparam logic [7:0] SFST_ADDR_TRIGCFG = 8'h0a;
  localparam logic [7:0] SFST_ADDR_SYSMODE = 8'h0b;
  localparam logic [7:0] SFST_TRIG_MASK    = 8'h3e; // bits 5..1 writable
  localparam logic [7:0] SFST_RESET_BYTE   = 8'h00;
  localparam logic [1:0] SFST_MODE_OFF     = 2'h0;
  localparam logic [1:0] SFST_MODE_TRIG    = 2'h3;
  localparam logic [1:0] SFST_SYS_STANDBY  = 2'h0;
  localparam logic [1:0] SFST_SYS_WAKE     = 2'h1;
  localparam logic [1:0] SFST_SYS_SLEEP    = 2'h2;
  localparam logic [5:0] SFST_CNT_FULL     = 6'h20;
  localparam logic [5:0] SFST_CNT_EMPTY    = 6'h00;
  localparam logic [4:0] SFST_FGT_MAX      = 5'h1f;
  localparam int         SFST_SNAP_DEPTH   = 4;
  localparam int         SFST_SNAP_AW      = 2;

  // power-mode sequencer states, gray along standby -> wake -> sleep
  typedef enum logic [1:0] {
    SFST_ST_STANDBY = 2'b00,
    SFST_ST_WAKE    = 2'b01,
    SFST_ST_SLEEP   = 2'b11
  } sfst_state_type;

  // detector interrupt flags, laid out as the trigger config bits 5..1
  typedef struct packed {
    logic trans;
    logic orient;
    logic pulse;
    logic ffmt;
    logic vecm;
  } sfst_detect_type;

  // per-sample events from the fifo core
  typedef struct packed {
    logic sampleIn;   // a sample is offered to the fifo this cycle
    logic sampleOut;  // host popped one sample
    logic flush;      // fifo emptied wholesale
  } sfst_fifo_ev_type;
endpackage

// ===== sfst_snap_mem.sv
/*
  small register-output memory holding the last read-back bytes of the status registers.
  assumes one writer and one reader on the same clock; read data lags the address by one cycle.
*/
`timescale 1ns/1ps
module sfst_snap_mem (
  // clock and reset
  input  wire logic                              mclk,
  input  wire logic                              rst,
  // write side
  input  wire logic                              wrEn,
  input  wire logic [sfst_pkg::SFST_SNAP_AW-1:0] wrAddr,
  input  wire logic [7:0]                        wrData,
  // read side
  input  wire logic [sfst_pkg::SFST_SNAP_AW-1:0] rdAddr,
  output logic      [7:0]                        rdData
);
  import sfst_pkg::*;
  logic [7:0] memArr [SFST_SNAP_DEPTH];

  // entries reset so reads never show unknowns
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      for (int i = 0; i < SFST_SNAP_DEPTH; i++) begin
        memArr[i] <= SFST_RESET_BYTE;
      end
    end else if (wrEn) begin
      memArr[wrAddr] <= wrData;
    end
  end

  // registered read data
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      rdData <= SFST_RESET_BYTE;
    end else begin
      rdData <= memArr[rdAddr];
    end
  end
endmodule

// ===== sfst_chk.sv
/* port checks for the fifo status and trigger block.
   assumes it is bound into sample_fifo_status_trigger. */
`timescale 1ns/1ps
module sfst_chk (
  // clock and reset
  input wire logic                       mclk,
  input wire logic                       rst,
  // register port
  input wire logic [7:0]                 regAddr,
  input wire logic                       regRd,
  input wire logic                       regWr,
  input wire logic [7:0]                 regWrData,
  input wire logic [7:0]                 regRdData,
  // fifo side and sources
  input wire logic [1:0]                 fifoMode,
  input wire sfst_pkg::sfst_fifo_ev_type fifoEv,
  input wire logic                       fifoAccept,
  input wire logic [7:0]                 axisReadyStatus,
  input wire sfst_pkg::sfst_detect_type  detectFlags,
  input wire logic                       aslpEvent,
  input wire logic                       srcFifo,
  input wire logic                       srcAslp
);
  import sfst_pkg::*;
  logic [7:0] cfgReg;
  default clocking @(posedge mclk); endclocking
  default disable iff (rst);
  // enables are write-only seen from here, so keep a shadow
  always_ff @(posedge mclk or posedge rst) begin
    if (rst)
      cfgReg <= 8'h00;
    else if (regWr && regAddr == 8'h0a)
      cfgReg <= regWrData & 8'h3e;
  end
  chk_alias_off: assert property ((regAddr == 8'h00 && fifoMode == 2'h0) |=> regRdData == $past(axisReadyStatus))
    else $error("alias byte wrong");
  chk_hole_zero: assert property (!(regAddr inside {8'h00, 8'h0a, 8'h0b}) |=> regRdData == 8'h00)
    else $error("unmapped read not zero");
  chk_cfg_unused: assert property (regAddr == 8'h0a |=> (regRdData & 8'hc1) == 8'h00)
    else $error("unused config bits set");
  chk_count_sat: assert property ((regAddr == 8'h00 && fifoMode != 2'h0) |=> regRdData[5:0] <= 6'h20)
    else $error("count above full");
  chk_sys_code: assert property (regAddr == 8'h0b |=> regRdData[1:0] != 2'b11)
    else $error("bad system mode code");
  chk_gate_stop: assert property ((fifoMode == 2'h3 && (detectFlags & cfgReg[5:1]) != 5'h00) |=> !fifoAccept)
    else $error("fifo not gated");
  chk_fifo_clear: assert property ((regRd && regAddr == 8'h00 && fifoMode != 2'h0 && !fifoEv.sampleIn) |=> !srcFifo)
    else $error("fifo source not cleared");
  chk_fifo_quiet: assert property ((!srcFifo && !fifoEv.sampleIn) |=> !srcFifo)
    else $error("fifo source set without sample");
  chk_aslp_clear: assert property ((regRd && regAddr == 8'h0b && !aslpEvent) |=> !srcAslp)
    else $error("sleep source not cleared");
  cover property (fifoMode == 2'h3 && !fifoAccept);
  cover property (regRd && regAddr == 8'h00 && srcFifo);
  cover property (srcAslp);
endmodule
bind sample_fifo_status_trigger sfst_chk sfst_chk_inst (.mclk(mclk), .rst(rst), .regAddr(regAddr), .regRd(regRd),
  .regWr(regWr), .regWrData(regWrData), .regRdData(regRdData), .fifoMode(fifoMode), .fifoEv(fifoEv),
  .fifoAccept(fifoAccept), .axisReadyStatus(axisReadyStatus), .detectFlags(detectFlags),
  .aslpEvent(aslpEvent), .srcFifo(srcFifo), .srcAslp(srcAslp));

// ===== sfst_host_model.sv
/* host side of the register port: one access per call.
   assumes read data lands one cycle after the taken address. */
`timescale 1ns/1ps
module sfst_host_model (
  // clock
  input  wire logic       mclk,
  // register port
  output logic      [7:0] regAddr,
  output logic            regRd,
  output logic            regWr,
  output logic      [7:0] regWrData,
  input  wire logic [7:0] regRdData
);
  // idle port at time zero
  initial begin
    regAddr = 8'h00;
    regRd = 1'b0;
    regWr = 1'b0;
    regWrData = 8'h00;
  end
  // strobe stands for exactly one taken edge
  task automatic acc(input logic wr, input logic [7:0] a, input logic [7:0] wd, output logic [7:0] d);
    @(posedge mclk);
    regAddr <= a;
    regRd <= !wr;
    regWr <= wr;
    regWrData <= wd;
    @(posedge mclk);
    regRd <= 1'b0;
    regWr <= 1'b0;
    #1 d = regRdData;
  endtask
endmodule

// ===== tb_sample_fifo_status_trigger.sv
/* self-checking bench with an integer model of the status block.
   assumes the host model drives the register port and the checker is bound. */
`timescale 1ns/1ps
module tb_sample_fifo_status_trigger;
  import sfst_pkg::*;
  logic             mclk = 1'b0;
  logic             rst = 1'b1;
  logic [7:0]       regAddr, regWrData, regRdData, d, axisReadyStatus = 8'h00, cfg = 8'h00;
  logic             regRd, regWr, fifoAccept, srcFifo, srcAslp;
  logic [1:0]       fifoMode = 2'h1;
  logic [5:0]       fifoWatermark = 6'h01, pls = 6'h00;
  sfst_fifo_ev_type fifoEv = '0;
  sfst_detect_type  detectFlags = '0;
  logic [7:0]       adr [4] = '{8'h00, 8'h0a, 8'h0b, 8'h05};
  int               numErrors, checksDone, cnt, ovf, trg, fge, fgt, sys, srcF, gate;
  always #2.5 mclk = ~mclk;
  sample_fifo_status_trigger sample_fifo_status_trigger_inst (.mclk(mclk), .rst(rst), .regAddr(regAddr),
    .regRd(regRd), .regWr(regWr), .regWrData(regWrData), .regRdData(regRdData), .fifoMode(fifoMode),
    .fifoWatermark(fifoWatermark), .fifoEv(fifoEv), .fifoAccept(fifoAccept), .axisReadyStatus(axisReadyStatus),
    .detectFlags(detectFlags), .gateErrEvent(pls[4]), .outputRateTick(pls[5]), .wakeReq(pls[0]),
    .sleepReq(pls[1]), .standbyReq(pls[2]), .aslpEvent(pls[3]), .srcFifo(srcFifo), .srcAslp(srcAslp));
  sfst_host_model sfst_host_model_inst (.mclk(mclk), .regAddr(regAddr), .regRd(regRd), .regWr(regWr),
    .regWrData(regWrData), .regRdData(regRdData));
  task automatic chk(logic [7:0] got, logic [7:0] exp);
    checksDone++;
    if (got !== exp) begin
      numErrors++;
      $display("ERROR %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic endOfTest;
    if (numErrors == 0 && checksDone > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask
  // expected read-back byte per address
  function automatic logic [7:0] expRd(logic [7:0] a);
    if (a == 8'h00)
      return (fifoMode == 2'h0) ? axisReadyStatus : {ovf[0], (fifoMode == 2'h3) ? trg[0] : cnt >= fifoWatermark, 6'(cnt)};
    return (a == 8'h0a) ? cfg : (a == 8'h0b) ? {fge[0], 5'(fgt), sys[1:0]} : 8'h00;
  endfunction
  task automatic rd(logic [7:0] a);
    sfst_host_model_inst.acc(1'b0, a, 8'h00, d);
    chk(d, expRd(a));
    if (a == 8'h00 && fifoMode != 2'h0) begin
      srcF = 0;
      chk({7'h0, srcFifo}, 8'h00);
    end
    if (a == 8'h0b)
      chk({7'h0, srcAslp}, 8'h00);
  endtask
  // fifo event; samples while gated are not counted
  task automatic ev(sfst_fifo_ev_type e);
    @(posedge mclk) fifoEv <= e;
    @(posedge mclk) fifoEv <= '0;
    #1;
    if (e.sampleIn && !gate) begin
      srcF |= (cnt == 32) || (cnt + 1 >= fifoWatermark);
      ovf |= (cnt == 32);
      cnt += (cnt < 32);
    end
    if (e.sampleOut && cnt > 0) begin
      cnt--;
      ovf = 0;
    end
    if (e.flush) begin
      cnt = 0;
      ovf = 0;
    end
    if (cnt == 0) begin
      fge = 0;
      fgt = 0;
    end
    if (fifoMode != 2'h3)
      chk({7'h0, srcFifo}, 8'(srcF));
  endtask
  task automatic pulse(int b);
    @(posedge mclk) pls[b] <= 1'b1;
    @(posedge mclk) pls <= 6'h00;
    #1;
  endtask
  // watchdog well beyond the fewer than five hundred cycles the run needs
  initial begin
    #400000;
    numErrors++;
    endOfTest;
  end
  initial begin
    void'($urandom(68));
    repeat (4) @(posedge mclk);
    rst <= 1'b0;
    for (int i = 0; i < 4; i++) rd(adr[i]);
    sfst_host_model_inst.acc(1'b1, 8'h0b, 8'hff, d);
    cfg = 8'($urandom);
    sfst_host_model_inst.acc(1'b1, 8'h0a, cfg, d);
    cfg &= SFST_TRIG_MASK;
    for (int i = 0; i < 4; i++) rd(adr[i]);
    @(posedge mclk) fifoMode <= 2'h0;
    axisReadyStatus <= 8'($urandom);
    rd(8'h00);
    @(posedge mclk) fifoMode <= 2'h1;
    fifoWatermark <= 6'($urandom_range(31, 1));
    repeat (33) begin
      ev(3'b100);
      rd(8'h00);
    end
    repeat (32) begin
      ev(3'b010);
      rd(8'h00);
    end
    // each enable gates; a disabled detector leaves the fifo open
    for (int i = 0; i < 5; i++) begin
      @(posedge mclk) fifoMode <= 2'h0;
      cfg = 8'(2 << i);
      sfst_host_model_inst.acc(1'b1, 8'h0a, cfg, d);
      @(posedge mclk) fifoMode <= 2'h3;
      detectFlags <= 5'(1 << ((i + 1) % 5));
      trg = 0;
      gate = 0;
      ev(3'b100);
      chk({7'h0, fifoAccept}, 8'h01);
      @(posedge mclk) detectFlags <= 5'(1 << i);
      repeat (2) @(posedge mclk);
      trg = 1;
      gate = 1;
      ev(3'b100);
      chk({7'h0, fifoAccept}, 8'h00);
      rd(8'h00);
      @(posedge mclk) detectFlags <= '0;
    end
    @(posedge mclk) fifoMode <= 2'h1;
    trg = 0;
    gate = 0;
    rd(8'h00);
    pulse(4);
    fge = 1;
    repeat (3) pulse(5);
    fgt = 3;
    rd(8'h0b);
    repeat (40) pulse(5);
    fgt = 31;
    rd(8'h0b);
    ev(3'b001);
    rd(8'h0b);
    // read back after each mode change, as a host using auto sleep would
    for (int i = 0; i < 3; i++) begin
      pulse(i);
      sys = (i + 1) % 3;
      rd(8'h0b);
    end
    pulse(3);
    chk({7'h0, srcAslp}, 8'h01);
    rd(8'h0b);
    endOfTest;
  end
endmodule
